// *** verilog/wdsp_port.sv ***
// serial configuration port, shadow/active registers and pattern memory
// assumes serial master runs mode 0 slowly enough for clk_sys sampling
// Behaviour
// - low chip select opens a transaction and starts taking bits.
// - first bit is direction, high read, low write.
// - next fifteen bits give start address, msb first.
// - address advances by one for each further word under chip select.
// - write transactions never drive the data line.
// - read transactions shift addressed contents out after the command.
// - chip select high ends the transaction; port waits for new command.
// - pattern memory of 4096 words sits at 0x6000 to 0x6fff.
// - double-line mode takes a second write data bit per clock on shared pin, not during the command word.
// - in double-line mode the shared pin is never driven.
// - shadow registers take writes anytime; active copy governs operation.
// - writing one to the update bit arms a shadow to active copy.
// - armed copy happens by itself once pattern generator is off.
// - pattern memory writes bypass the shadow mechanism.
// - all words shift msb first in both directions.
// - one 14-bit code per sample enable goes to the converter.
// - four-wire mode sends read data on the shared pin, and on no pin while double-line mode is on.
// - low reset pin returns configuration registers to defaults.
`timescale 1ns/1ps
module wdsp_port
  import wdsp_pkg::*;
#(
  parameter int CFG_NUM = WDSP_CFG_NUM
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_n,
  input wire logic shared_out_or_second_in_pin_i,
  output logic shared_out_or_second_in_pin_o,
  output logic shared_out_or_second_in_pin_oe_n,
  input wire logic four_wire,
  input wire logic double_mode,
  input wire logic pattern_on,
  input wire logic sample_en,
  output logic [CFG_NUM*WDSP_WORD_W-1:0] cfg_active,
  output logic [WDSP_CODE_W-1:0] dac_code
);
  // ==========================================================================
  // parameter check
  generate
    if (CFG_NUM < 1 || CFG_NUM > int'(WDSP_UPD_ADDR)) begin : g_chk
      $error("wdsp_port CFG_NUM out of range");
    end
  endgenerate

  // ==========================================================================
  // pin synchronisers
  logic [3:0] pins_f;
  logic sclk_f;
  logic cs_n_f;
  logic sdio_f;
  logic sdi2_f;
  logic rst_pin_f;
  logic rst;

  // reset to the idle levels: sclk low, chip select high, data low;
  // a low chip select straight out of reset would look like a frame
  wdsp_sync #(.W(4), .INIT(4'b0100)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .d({sclk, cs_n, sdio_i, shared_out_or_second_in_pin_i}),
    .q(pins_f)
  );

  wdsp_sync #(.W(1), .INIT(1'b1)) u_sync_rst (
    .clk_sys(clk_sys),
    .reset(reset),
    .d(reset_pin_n),
    .q(rst_pin_f)
  );

  assign sclk_f = pins_f[3];
  assign cs_n_f = pins_f[2];
  assign sdio_f = pins_f[1];
  assign sdi2_f = pins_f[0];
  assign rst = reset | ~rst_pin_f;

  // ==========================================================================
  // state
  typedef struct packed {
    logic sclk_prev;
    logic cmd_done;
    logic rd;
    logic [3:0] bitcnt;
    logic [WDSP_ADDR_W-1:0] addr;
    logic [WDSP_WORD_W-1:0] in_sr;
    logic [WDSP_WORD_W-1:0] out_sr;
    logic out_bit;
    logic armed;
    logic [CFG_NUM-1:0][WDSP_WORD_W-1:0] shadow;
    logic [CFG_NUM-1:0][WDSP_WORD_W-1:0] active;
    logic [WDSP_MEM_AW-1:0] play_addr;
    logic [WDSP_CODE_W-1:0] code;
  } wdsp_state_t;

  wdsp_state_t st_q;
  wdsp_state_t st_d;

  logic [WDSP_CODE_W-1:0] mem [WDSP_MEM_DEPTH];
  logic mem_we;
  logic [WDSP_MEM_AW-1:0] mem_waddr;
  logic [WDSP_CODE_W-1:0] mem_wdata;

  logic rise;
  logic fall;
  logic dbl;
  logic [WDSP_WORD_W-1:0] word;
  logic word_end;
  logic [WDSP_ADDR_W-1:0] rd_addr;
  logic [WDSP_WORD_W-1:0] rdata;

  assign rise = sclk_f & ~st_q.sclk_prev;
  assign fall = ~sclk_f & st_q.sclk_prev;
  // double-line only for write data, never during the command word
  assign dbl = double_mode & st_q.cmd_done & ~st_q.rd;

  // ==========================================================================
  // word assembly
  always_comb begin
    if (dbl) begin
      word = {st_q.in_sr[13:0], sdio_f, sdi2_f};
      word_end = (st_q.bitcnt == WDSP_CNT_LAST_2);
    end else begin
      word = {st_q.in_sr[14:0], sdio_f};
      word_end = (st_q.bitcnt == WDSP_CNT_LAST_1);
    end
    if (st_q.cmd_done) begin
      rd_addr = st_q.addr + 15'h0001;
    end else begin
      rd_addr = word[WDSP_ADDR_W-1:0];
    end
  end

  // ==========================================================================
  // read mux
  always_comb begin
    rdata = '0;
    if (rd_addr[14:12] == WDSP_MEM_BASE[14:12]) begin
      rdata = {2'h0, mem[rd_addr[WDSP_MEM_AW-1:0]]};
    end else if (rd_addr < 15'(CFG_NUM)) begin
      rdata = st_q.shadow[rd_addr[$clog2(CFG_NUM+1)-1:0]];
    end else if (rd_addr == WDSP_UPD_ADDR) begin
      rdata[WDSP_UPD_BIT] = st_q.armed;
    end else if (rd_addr == WDSP_STAT_ADDR) begin
      rdata[WDSP_STAT_PAT_BIT] = pattern_on;
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    st_d = st_q;
    mem_we = 1'b0;
    mem_waddr = st_q.addr[WDSP_MEM_AW-1:0];
    mem_wdata = st_q.in_sr[WDSP_CODE_W-1:0];
    st_d.sclk_prev = sclk_f;

    // armed copy waits for the generator to stop
    if (st_q.armed && !pattern_on) begin
      st_d.active = st_q.shadow;
      st_d.armed = 1'b0;
    end

    if (cs_n_f) begin
      st_d.bitcnt = 4'h0;
      st_d.cmd_done = 1'b0;
      st_d.rd = 1'b0;
      st_d.out_bit = 1'b0;
    end else if (rise) begin
      st_d.in_sr = word;
      st_d.bitcnt = dbl ? st_q.bitcnt + 4'h2 : st_q.bitcnt + 4'h1;
      if (word_end) begin
        if (!st_q.cmd_done) begin
          st_d.cmd_done = 1'b1;
          st_d.rd = word[WDSP_DIR_BIT];
          st_d.addr = word[WDSP_ADDR_W-1:0];
          st_d.out_sr = rdata;
        end else if (st_q.rd) begin
          st_d.addr = rd_addr;
          st_d.out_sr = rdata;
        end else begin
          st_d.addr = rd_addr;
          if (st_q.addr[14:12] == WDSP_MEM_BASE[14:12]) begin
            // memory goes straight in, no shadow stage
            mem_we = 1'b1;
            mem_wdata = word[WDSP_CODE_W-1:0];
          end else if (st_q.addr < 15'(CFG_NUM)) begin
            st_d.shadow[st_q.addr[$clog2(CFG_NUM+1)-1:0]] = word;
          end else if (st_q.addr == WDSP_UPD_ADDR && word[WDSP_UPD_BIT]) begin
            st_d.armed = 1'b1;
          end
        end
      end
    end else if (fall && st_q.cmd_done && st_q.rd) begin
      st_d.out_bit = st_q.out_sr[WDSP_WORD_W-1];
      st_d.out_sr = {st_q.out_sr[14:0], 1'b0};
    end

    // playback; a memory write may land the same cycle it is read
    if (!pattern_on) begin
      st_d.play_addr = '0;
    end else if (sample_en) begin
      st_d.code = mem[st_q.play_addr];
      st_d.play_addr = st_q.play_addr + 12'h001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= '0;
      st_q.shadow <= {CFG_NUM{WDSP_CFG_RST}};
      st_q.active <= {CFG_NUM{WDSP_CFG_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  // memory holds its content across reset, as a plain ram would
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // ==========================================================================
  // pin drive
  logic driving;
  assign driving = ~cs_n_f & st_q.cmd_done & st_q.rd;
  assign sdio_o = st_q.out_bit;
  assign sdio_oe_n = ~(driving & ~four_wire);
  assign shared_out_or_second_in_pin_o = st_q.out_bit;
  assign shared_out_or_second_in_pin_oe_n =
    ~(driving & four_wire & ~double_mode);
  assign cfg_active = st_q.active;
  assign dac_code = st_q.code;

  // ==========================================================================
  // checks
  wr_no_drive_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q.cmd_done && !st_q.rd)
      |-> (sdio_oe_n && shared_out_or_second_in_pin_oe_n))
    else $error("data line driven during write");
  dbl_no_drive_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    double_mode |-> shared_out_or_second_in_pin_oe_n)
    else $error("shared pin driven in double mode");
  idle_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    cs_n_f |-> ##1 (sdio_oe_n && shared_out_or_second_in_pin_oe_n
      && !st_q.cmd_done))
    else $error("port active after chip select high");
  addr_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!cs_n_f && rise && word_end && st_q.cmd_done)
      |=> st_q.addr == $past(st_q.addr) + 15'h0001)
    else $error("address did not advance by one");
  copy_done_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q.armed && !pattern_on) |=> st_q.active == $past(st_q.shadow))
    else $error("armed copy not taken while generator off");
  active_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    ($past(pattern_on) && pattern_on) |-> $stable(st_q.active))
    else $error("active set changed while generating");
  out_on_fall_a: assert property (@(posedge clk_sys) disable iff (rst)
    ($changed(st_q.out_bit) && !$past(cs_n_f)) |-> $past(fall))
    else $error("read bit changed outside falling edge");
  dir_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (st_q.cmd_done && $past(st_q.cmd_done)) |-> $stable(st_q.rd))
    else $error("direction changed inside transaction");
  mem_range_a: assert property (@(posedge clk_sys) disable iff (rst)
    mem_we |-> (st_q.addr >= WDSP_MEM_BASE && st_q.addr <= WDSP_MEM_LAST))
    else $error("memory written outside its window");
  cfg_reset_a: assert property (@(posedge clk_sys)
    $past(rst) |-> (st_q.active == {CFG_NUM{WDSP_CFG_RST}} && !st_q.armed))
    else $error("configuration not at default after reset");
  cut_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    cs_n_f |=> (st_q.bitcnt == 4'h0 && !st_q.rd))
    else $error("partial word kept after chip select high");
  rd_drive_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!cs_n_f && st_q.cmd_done && st_q.rd && !four_wire) |-> !sdio_oe_n)
    else $error("read data line not driven");
  play_rewind_a: assert property (@(posedge clk_sys) disable iff (rst)
    !pattern_on |=> st_q.play_addr == '0)
    else $error("playback address not rewound while off");

  rd_seen_c: cover property (@(posedge clk_sys) disable iff (rst)
    driving && fall);
  dbl_mem_c: cover property (@(posedge clk_sys) disable iff (rst)
    mem_we && dbl);
  copy_seen_c: cover property (@(posedge clk_sys) disable iff (rst)
    st_q.armed && !pattern_on);
  play_c: cover property (@(posedge clk_sys) disable iff (rst)
    pattern_on && sample_en);
  cut_frame_c: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(cs_n_f) && st_q.bitcnt != 4'h0);
endmodule : wdsp_port

// *** verilog/wdsp_pkg.sv ***
// constants for the waveform dac serial configuration port
// assumes a single system clock; serial pins are sampled, not used as clocks
package wdsp_pkg;
  // ==========================================================================
  // word and address layout
  localparam int WDSP_WORD_W = 16;
  localparam int WDSP_ADDR_W = 15;
  localparam int WDSP_CODE_W = 14;
  localparam int WDSP_MEM_AW = 12;
  localparam int WDSP_MEM_DEPTH = 4096;
  localparam int WDSP_CFG_NUM = 16;
  localparam int WDSP_DIR_BIT = 15;
  // ==========================================================================
  // address map
  localparam logic [14:0] WDSP_MEM_BASE = 15'h6000;
  localparam logic [14:0] WDSP_MEM_LAST = 15'h6fff;
  localparam logic [14:0] WDSP_UPD_ADDR = 15'h001d;
  localparam logic [14:0] WDSP_STAT_ADDR = 15'h001e;
  localparam int WDSP_UPD_BIT = 0;
  localparam int WDSP_STAT_PAT_BIT = 1;
  // ==========================================================================
  // reset values and word-end bit counts
  localparam logic [15:0] WDSP_CFG_RST = 16'h0000;
  localparam logic [3:0] WDSP_CNT_LAST_1 = 4'hf;
  localparam logic [3:0] WDSP_CNT_LAST_2 = 4'he;
endpackage : wdsp_pkg

// *** verilog/wdsp_sync.sv ***
// three-flop input synchroniser with agreement filter
// assumes inputs arrive asynchronously to clk_sys
`timescale 1ns/1ps
module wdsp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ==========================================================================
  // stages
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;

  generate
    if (W < 1) begin : g_chk
      $error("wdsp_sync width must be at least one");
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      q_q <= INIT;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // per bit: take a change only once two late stages agree
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign q = q_q;
endmodule : wdsp_sync

// *** tb/wdsp_master_model.sv ***
// serial master model for the configuration port: mode 0, msb first
// assumes the bench drives at falling clk_sys; one sclk half period is 80 ns
`timescale 1ns/1ps
module wdsp_master_model (
  input wire logic clk_sys,
  input wire logic sdio_o,
  input wire logic sdio_oe_n,
  input wire logic sec_o,
  input wire logic sec_oe_n,
  output logic sclk,
  output logic cs_n,
  output logic sdio_i,
  output logic sec_i
);
  // ==========================================================================
  // wire resolution
  logic m_d = 1'b0;
  logic m_s = 1'b0;
  logic drv_seen = 1'b0;
  logic [15:0] wr_w [0:3];
  logic [15:0] rd_w [0:3];
  initial sclk = 1'b0;
  initial cs_n = 1'b1;
  // released lines have no pull, so they keep changing instead of holding
  assign sdio_i = sdio_oe_n ? m_d : sdio_o;
  assign sec_i = sec_oe_n ? m_s : sec_o;
  always @(negedge clk_sys) begin
    if (!sdio_oe_n || !sec_oe_n) begin
      drv_seen = 1'b1;
    end
  end
  // ==========================================================================
  // transactions
  task automatic half;
    repeat (10) @(negedge clk_sys);
  endtask : half
  task automatic run(input logic [15:0] cmd, input int n, input logic dbl,
                     input logic four);
    int b;
    int w;
    int st;
    st = dbl ? 2 : 1;
    drv_seen = 1'b0;
    cs_n = 1'b0;
    half;
    for (b = 15; b >= 0; b--) begin
      m_d = cmd[b];
      m_s = ~m_s;
      half;
      sclk = 1'b1;
      half;
      sclk = 1'b0;
    end
    for (w = 0; w < n; w++) begin
      for (b = 15; b >= 0; b -= st) begin
        if (cmd[15]) begin
          m_d = ~m_d;
        end else begin
          m_d = wr_w[w][b];
        end
        m_s = (dbl && !cmd[15]) ? wr_w[w][b-1] : ~m_s;
        half;
        sclk = 1'b1;
        rd_w[w][b] = four ? sec_i : sdio_i;
        half;
        sclk = 1'b0;
      end
    end
    half;
    cs_n = 1'b1;
    m_d = ~m_d;
    half;
  endtask : run
  // a frame cut short: the command, then nb ones, then chip select high
  task automatic cut(input logic [15:0] cmd, input int nb);
    int b;
    cs_n = 1'b0;
    half;
    for (b = 0; b < 16 + nb; b++) begin
      m_d = (b < 16) ? cmd[15 - b] : 1'b1;
      m_s = ~m_s;
      half;
      sclk = 1'b1;
      half;
      sclk = 1'b0;
    end
    half;
    cs_n = 1'b1;
    m_d = ~m_d;
    half;
  endtask : cut
endmodule : wdsp_master_model

// *** tb/test_wdsp_port.sv ***
// self-checking bench for the configuration port
// assumes the master model above and the port's register map choices
`timescale 1ns/1ps
module test_wdsp_port
  import wdsp_pkg::*;
;
  // ==========================================================================
  // stimulus and wiring
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic reset_pin_n = 1'b1;
  logic four_wire = 1'b0;
  logic double_mode = 1'b0;
  logic pattern_on = 1'b0;
  logic sample_en = 1'b0;
  logic sclk, cs_n, sdio_i, sdio_o, sdio_oe_n, sec_i, sec_o, sec_oe_n;
  logic [WDSP_CFG_NUM*WDSP_WORD_W-1:0] cfg_active;
  logic [WDSP_CODE_W-1:0] dac_code;
  int bad_count = 0;
  int num_checks = 0;
  always #4 clk_sys = ~clk_sys;
  wdsp_port dut_u (.clk_sys(clk_sys), .reset(reset),
    .reset_pin_n(reset_pin_n), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i),
    .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n),
    .shared_out_or_second_in_pin_i(sec_i),
    .shared_out_or_second_in_pin_o(sec_o),
    .shared_out_or_second_in_pin_oe_n(sec_oe_n), .four_wire(four_wire),
    .double_mode(double_mode), .pattern_on(pattern_on),
    .sample_en(sample_en), .cfg_active(cfg_active), .dac_code(dac_code));
  wdsp_master_model mdl_u (.clk_sys(clk_sys), .sdio_o(sdio_o),
    .sdio_oe_n(sdio_oe_n), .sec_o(sec_o), .sec_oe_n(sec_oe_n),
    .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i), .sec_i(sec_i));
  // ==========================================================================
  // checking and ending
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  // ==========================================================================
  // scenarios
  task automatic t_reset;
    check({63'h0, |cfg_active}, 64'h0);
    check({50'h0, dac_code}, 64'h0);
    check({62'h0, sdio_oe_n, sec_oe_n}, 64'h3);
  endtask : t_reset
  task automatic t_shadow;
    pattern_on = 1'b1;
    mdl_u.wr_w[0] = 16'ha5c3;
    mdl_u.wr_w[1] = 16'h1234;
    mdl_u.wr_w[2] = 16'hffff;
    mdl_u.run(16'h0000, 3, 1'b0, 1'b0);
    check({63'h0, mdl_u.drv_seen}, 64'h0);
    mdl_u.wr_w[0] = 16'h0001;
    mdl_u.run(16'h001d, 1, 1'b0, 1'b0);
    check(cfg_active[63:0], 64'h0);
    mdl_u.run(16'h801d, 1, 1'b0, 1'b0);
    check({48'h0, mdl_u.rd_w[0]}, 64'h0001);
    pattern_on = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(cfg_active[63:0], 64'h0000_ffff_1234_a5c3);
    mdl_u.run(16'h8000, 3, 1'b0, 1'b0);
    check({16'h0, mdl_u.rd_w[0], mdl_u.rd_w[1], mdl_u.rd_w[2]},
          64'h0000_a5c3_1234_ffff);
    four_wire = 1'b1;
    mdl_u.run(16'h8001, 1, 1'b0, 1'b1);
    check({48'h0, mdl_u.rd_w[0]}, 64'h1234);
    mdl_u.run(16'h8100, 1, 1'b0, 1'b1);
    check({48'h0, mdl_u.rd_w[0]}, 64'h0);
    four_wire = 1'b0;
    // the pin passes a synchroniser, so hold it well past its latency
    reset_pin_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    reset_pin_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    check({63'h0, |cfg_active}, 64'h0);
    // one full word, then a partial one that must be dropped
    mdl_u.cut(16'h0002, 24);
    mdl_u.run(16'h8002, 2, 1'b0, 1'b0);
    check({32'h0, mdl_u.rd_w[0], mdl_u.rd_w[1]}, 64'hffff_0000);
  endtask : t_shadow
  task automatic t_memory;
    double_mode = 1'b1;
    mdl_u.wr_w[0] = 16'h3fff;
    mdl_u.wr_w[1] = 16'h2a55;
    mdl_u.run(16'h6000, 2, 1'b1, 1'b0);
    check({63'h0, mdl_u.drv_seen}, 64'h0);
    // a four-wire read in double mode must leave both lines undriven
    four_wire = 1'b1;
    mdl_u.run(16'h8000, 1, 1'b0, 1'b1);
    check({63'h0, mdl_u.drv_seen}, 64'h0);
    four_wire = 1'b0;
    double_mode = 1'b0;
    mdl_u.run(16'he000, 2, 1'b0, 1'b0);
    check({32'h0, mdl_u.rd_w[0], mdl_u.rd_w[1]},
          64'h3fff_2a55);
    pattern_on = 1'b1;
    sample_en = 1'b1;
    @(negedge clk_sys);
    sample_en = 1'b0;
    @(negedge clk_sys);
    check({50'h0, dac_code}, 64'h3fff);
    sample_en = 1'b1;
    @(negedge clk_sys);
    sample_en = 1'b0;
    @(negedge clk_sys);
    check({50'h0, dac_code}, 64'h2a55);
    mdl_u.run(16'h801e, 1, 1'b0, 1'b0);
    check({48'h0, mdl_u.rd_w[0]}, 64'h0002);
    pattern_on = 1'b0;
  endtask : t_memory
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    repeat (8) @(negedge clk_sys);
    t_reset;
    t_shadow;
    t_memory;
    stop_test;
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    bad_count++;
    stop_test;
  end
endmodule : test_wdsp_port
